// >>> hdl/mbxhs_defines.vh
/*
 mailbox handshake flow control: register offsets, field layout and reset values.
 assumes it is included by bare name from the design file; definitions only.
*/
`ifndef MBXHS_DEFINES_VH
`define MBXHS_DEFINES_VH

// ***************************************************************
// register map (byte addresses; mailboxes and status on both avalon ports, cfg registers on the master port only)
// ***************************************************************
`define MBXHS_OFS_MBX_BASE   7'h00
`define MBXHS_OFS_STATUS     7'h40
`define MBXHS_OFS_CFG_ASSIGN 7'h44
`define MBXHS_OFS_CFG_ENABLE 7'h48
`define MBXHS_OFS_CFG_DIR    7'h4c

// ***************************************************************
// field layout
// ***************************************************************
`define MBXHS_MBX_SEL_BIT    6
`define MBXHS_IDX_MSB        5
`define MBXHS_IDX_LSB        2
`define MBXHS_ASSIGN_W       4
`define MBXHS_EN_COUPLE_BIT  8
`define MBXHS_BE_MSB_LANE    1
`define MBXHS_BE_LSB_LANE    0

// ***************************************************************
// reset values and crossing depth
// ***************************************************************
`define MBXHS_RST_DATA       16'h0000
`define MBXHS_RST_ASSIGN     32'h0000_0000
`define MBXHS_RST_ENABLE     8'h00
`define MBXHS_RST_DIR        16'h0000
`define MBXHS_RST_READ       32'h0000_0000
`define MBXHS_SYNC_STAGES    2

`endif

// >>> hdl/mbxhs_mailbox_handshake.v
/*
 mailbox handshake flow control: sixteen 16-bit mailboxes shared by a master
 and a slave processor, with eight handshake blocks that each guard one
 mailbox and flag data-ready / ready-to-write to both sides.
 assumes both processor buses are avalon-mm slaves on clk_sys, that reset is
 the power-on/brown-out reset and that master_reset and slave_reset come from
 on-chip reset logic on clk_sys.
*/
// The register addresses and the Avalon-MM slave port are this design's own decisions.
`include "mbxhs_defines.vh"
`timescale 1ns/1ps
`default_nettype none

module mbxhs_mailbox_handshake #(
   parameter NUM_BLOCKS = 8,
   parameter NUM_MBX    = 16
) (
   input  wire        clk_sys,
   input  wire        reset,
   input  wire        master_reset,
   input  wire        slave_reset,
   input  wire [6:0]  m_address,
   input  wire        m_read,
   input  wire        m_write,
   input  wire [3:0]  m_byteenable,
   input  wire [31:0] m_writedata,
   output reg  [31:0] m_readdata,
   output reg         m_waitrequest,
   input  wire [6:0]  s_address,
   input  wire        s_read,
   input  wire        s_write,
   input  wire [3:0]  s_byteenable,
   input  wire [31:0] s_writedata,
   output reg  [31:0] s_readdata,
   output reg         s_waitrequest,
   output reg  [7:0]  m_irq,
   output reg  [7:0]  s_irq,
   output reg         slave_reset_out
);

   // ***************************************************************
   // configuration (fuse-like, master side, cleared only by reset)
   // ***************************************************************
   reg  [31:0] handshake_assign_word;
   reg  [7:0]  handshake_enable_word;
   reg         master_slave_reset_coupling;
   reg  [15:0] mailbox_direction_word;   // bit n set: master transmits on mailbox n

   reg  [15:0] mailbox_data_reg [0:NUM_MBX-1];
   reg  [7:0]  tx_flag;
   reg  [7:0]  rx_flag;
   reg  [1:0]  set_pipe [0:NUM_BLOCKS-1];
   reg  [1:0]  clr_pipe [0:NUM_BLOCKS-1];

   wire        m_wr_go = m_write & ~m_waitrequest;
   wire        m_rd_go = m_read & ~m_waitrequest;
   wire        s_wr_go = s_write & ~s_waitrequest;
   wire        s_rd_go = s_read & ~s_waitrequest;
   wire        m_mbx   = ~m_address[`MBXHS_MBX_SEL_BIT];
   wire        s_mbx   = ~s_address[`MBXHS_MBX_SEL_BIT];
   wire [3:0]  m_idx   = m_address[`MBXHS_IDX_MSB:`MBXHS_IDX_LSB];
   wire [3:0]  s_idx   = s_address[`MBXHS_IDX_MSB:`MBXHS_IDX_LSB];
   wire        m_rst   = reset | master_reset;

   wire [7:0]  wr_ev;
   wire [7:0]  rd_ev;
   wire [7:0]  m_is_tx;
   wire [7:0]  m_view;
   wire [7:0]  s_view;

   // picks the 4-bit mailbox selection of one block
   function [3:0] block_sel;
      input [31:0] word;
      input [2:0]  blk;
      begin
         block_sel = word[blk*4 +: 4];
      end
   endfunction

   // byte-lane merge of a write into a 16-bit mailbox
   function [15:0] lane_merge;
      input [15:0] old;
      input [15:0] wdata;
      input [1:0]  be;
      begin
         lane_merge = {be[1] ? wdata[15:8] : old[15:8],
                       be[0] ? wdata[7:0]  : old[7:0]};
      end
   endfunction

   // ***************************************************************
   // handshake blocks
   // ***************************************************************
   genvar gb;
   generate
      for (gb = 0; gb < NUM_BLOCKS; gb = gb + 1) begin : g_blk
         localparam [2:0] BLK = gb;
         wire [3:0] sel  = block_sel(handshake_assign_word, BLK);
         wire       en   = handshake_enable_word[gb];
         wire       mtx  = mailbox_direction_word[sel];
         wire       m_hit = m_mbx & (m_idx == sel) & m_byteenable[`MBXHS_BE_MSB_LANE];
         wire       s_hit = s_mbx & (s_idx == sel) & s_byteenable[`MBXHS_BE_MSB_LANE];

         assign m_is_tx[gb] = mtx;
         // transmitter write, word or high byte only
         assign wr_ev[gb] = en & (mtx ? (m_wr_go & m_hit) : (s_wr_go & s_hit));
         // receiver read, effective only while its flag is set
         assign rd_ev[gb] = en & rx_flag[gb] &
                            (mtx ? (s_rd_go & s_hit) : (m_rd_go & m_hit));
         assign m_view[gb] = mtx ? tx_flag[gb] : rx_flag[gb];
         assign s_view[gb] = mtx ? rx_flag[gb] : tx_flag[gb];

         // slave_reset is deliberately absent here
         always @(posedge clk_sys) begin
            if (m_rst || !en) begin
               tx_flag[gb]  <= 1'b0;
               rx_flag[gb]  <= 1'b0;
               set_pipe[gb] <= 2'h0;
               clr_pipe[gb] <= 2'h0;
            end else begin
               set_pipe[gb] <= {set_pipe[gb][0], wr_ev[gb]};
               clr_pipe[gb] <= {clr_pipe[gb][0], rd_ev[gb]};
               if (wr_ev[gb])
                  tx_flag[gb] <= 1'b1;
               else if (clr_pipe[gb][1])
                  tx_flag[gb] <= 1'b0;
               if (set_pipe[gb][1])
                  rx_flag[gb] <= 1'b1;
               else if (rd_ev[gb])
                  rx_flag[gb] <= 1'b0;
            end
         end

         always @(posedge clk_sys) begin
            if (m_rst) begin
               m_irq[gb] <= 1'b0;
               s_irq[gb] <= 1'b0;
            end else begin
               // receiver gets ready-to-read, transmitter ready-to-write
               m_irq[gb] <= en & (mtx ? clr_pipe[gb][1] : set_pipe[gb][1]);
               s_irq[gb] <= en & (mtx ? set_pipe[gb][1] : clr_pipe[gb][1]);
            end
         end
      end
   endgenerate

   // ***************************************************************
   // mailbox storage: only the transmitting side may write a mailbox
   // ***************************************************************
   genvar gm;
   generate
      for (gm = 0; gm < NUM_MBX; gm = gm + 1) begin : g_mbx
         always @(posedge clk_sys) begin
            if (reset)
               mailbox_data_reg[gm] <= `MBXHS_RST_DATA;
            else if (m_wr_go && m_mbx && m_idx == gm && mailbox_direction_word[gm])
               mailbox_data_reg[gm] <= lane_merge(mailbox_data_reg[gm], m_writedata[15:0],
                                                  m_byteenable[1:0]);
            else if (s_wr_go && s_mbx && s_idx == gm && !mailbox_direction_word[gm])
               mailbox_data_reg[gm] <= lane_merge(mailbox_data_reg[gm], s_writedata[15:0],
                                                  s_byteenable[1:0]);
         end
      end
   endgenerate

   // ***************************************************************
   // configuration registers (master bus)
   // ***************************************************************
   always @(posedge clk_sys) begin
      if (reset) begin
         handshake_assign_word       <= `MBXHS_RST_ASSIGN;
         handshake_enable_word       <= `MBXHS_RST_ENABLE;
         master_slave_reset_coupling <= 1'b0;
         mailbox_direction_word      <= `MBXHS_RST_DIR;
      end else if (m_wr_go) begin
         case (m_address)
            `MBXHS_OFS_CFG_ASSIGN: begin
               handshake_assign_word <= m_writedata;
            end
            `MBXHS_OFS_CFG_ENABLE: begin
               handshake_enable_word       <= m_writedata[7:0];
               master_slave_reset_coupling <= m_writedata[`MBXHS_EN_COUPLE_BIT];
            end
            `MBXHS_OFS_CFG_DIR: begin
               mailbox_direction_word <= m_writedata[15:0];
            end
            default: begin
            end
         endcase
      end
   end

   // coupled resets carry a master reset into the slave
   always @(posedge clk_sys) begin
      if (reset)
         slave_reset_out <= 1'b1;
      else
         slave_reset_out <= master_reset & master_slave_reset_coupling;
   end

   // ***************************************************************
   // avalon answer: one wait cycle, then the request is taken
   // ***************************************************************
   always @(posedge clk_sys) begin
      if (m_rst) begin
         m_waitrequest <= 1'b1;
         m_readdata    <= `MBXHS_RST_READ;
      end else begin
         m_waitrequest <= ~((m_read | m_write) & m_waitrequest);
         if (m_read && m_waitrequest) begin
            if (m_mbx)
               m_readdata <= {16'h0000, mailbox_data_reg[m_idx]};
            else
               case (m_address)
                  `MBXHS_OFS_STATUS:     m_readdata <= {24'h000000, m_view};
                  `MBXHS_OFS_CFG_ASSIGN: m_readdata <= handshake_assign_word;
                  `MBXHS_OFS_CFG_ENABLE: m_readdata <= {23'h000000, master_slave_reset_coupling,
                                                         handshake_enable_word};
                  `MBXHS_OFS_CFG_DIR:    m_readdata <= {16'h0000, mailbox_direction_word};
                  default:               m_readdata <= `MBXHS_RST_READ;
               endcase
         end
      end
   end

   always @(posedge clk_sys) begin
      if (reset || slave_reset) begin
         s_waitrequest <= 1'b1;
         s_readdata    <= `MBXHS_RST_READ;
      end else begin
         s_waitrequest <= ~((s_read | s_write) & s_waitrequest);
         if (s_read && s_waitrequest) begin
            if (s_mbx)
               s_readdata <= {16'h0000, mailbox_data_reg[s_idx]};
            else if (s_address == `MBXHS_OFS_STATUS)
               s_readdata <= {24'h000000, s_view};
            else
               s_readdata <= `MBXHS_RST_READ;
         end
      end
   end

endmodule

`default_nettype wire

// >>> verification/mbxhs_mailbox_handshake_sva.sv
/*
 checker for the mailbox handshake block: bus answer timing and interrupt causes.
 assumes one clock, clk_sys, and that it is bound to the design's top module.
*/
`timescale 1ns/1ps
`default_nettype none
module mbxhs_mailbox_handshake_sva (
   input wire logic       clk_sys,
   input wire logic       reset,
   input wire logic       master_reset,
   input wire logic       slave_reset,
   input wire logic       m_read,
   input wire logic       m_write,
   input wire logic [3:0] m_byteenable,
   input wire logic       m_waitrequest,
   input wire logic       s_read,
   input wire logic       s_write,
   input wire logic [3:0] s_byteenable,
   input wire logic       s_waitrequest,
   input wire logic [7:0] m_irq,
   input wire logic [7:0] s_irq
);
   // ***************************************************************
   // handshake accesses that commit on each bus
   // ***************************************************************
   logic m_hs;
   logic s_hs;
   assign m_hs = (m_read || m_write) && !m_waitrequest && m_byteenable[1];
   assign s_hs = (s_read || s_write) && !s_waitrequest && s_byteenable[1];
   default clocking cb @(posedge clk_sys); endclocking
   property p_m_wait_drop;
      disable iff (reset || master_reset) (m_read || m_write) && m_waitrequest |=> !m_waitrequest;
   endproperty
   a_m_wait_drop: assert property (p_m_wait_drop) else $error("master request not answered");
   property p_m_wait_one;
      disable iff (reset || master_reset) !m_waitrequest |=> m_waitrequest;
   endproperty
   a_m_wait_one: assert property (p_m_wait_one) else $error("master answer too long");
   property p_s_wait_drop;
      disable iff (reset || slave_reset) (s_read || s_write) && s_waitrequest |=> !s_waitrequest;
   endproperty
   a_s_wait_drop: assert property (p_s_wait_drop) else $error("slave request not answered");
   property p_s_wait_one;
      disable iff (reset || slave_reset) !s_waitrequest |=> s_waitrequest;
   endproperty
   a_s_wait_one: assert property (p_s_wait_one) else $error("slave answer too long");
   property p_irq_clear;
      disable iff (reset) master_reset |=> (m_irq == 8'h00) && (s_irq == 8'h00);
   endproperty
   a_irq_clear: assert property (p_irq_clear) else $error("interrupt under master reset");
   property p_m_irq_pulse;
      disable iff (reset || master_reset) (m_irq != 8'h00) |=> ((m_irq & $past(m_irq)) == 8'h00);
   endproperty
   a_m_irq_pulse: assert property (p_m_irq_pulse) else $error("master interrupt not a pulse");
   property p_s_irq_cause;
      disable iff (reset || master_reset) (s_irq != 8'h00) |-> $past(m_hs, 2) || $past(m_hs, 3) || $past(m_hs, 4);
   endproperty
   a_s_irq_cause: assert property (p_s_irq_cause) else $error("slave interrupt without cause");
   property p_m_irq_cause;
      disable iff (reset || master_reset) (m_irq != 8'h00) |-> $past(s_hs, 2) || $past(s_hs, 3) || $past(s_hs, 4);
   endproperty
   a_m_irq_cause: assert property (p_m_irq_cause) else $error("master interrupt without cause");
   c_s_irq: cover property (s_irq[0]);
   c_m_irq: cover property (m_irq[1]);
   c_mrst: cover property (master_reset ##1 !master_reset);
endmodule
bind mbxhs_mailbox_handshake mbxhs_mailbox_handshake_sva i_sva (.*);
`default_nettype wire

// >>> verification/mbxhs_cpu.sv
/*
 processor model: an avalon-mm master for either bus of the mailbox block.
 assumes clk_sys and a slave that answers by dropping waitrequest.
*/
`timescale 1ns/1ps
`default_nettype none
module mbxhs_cpu (
   input  wire logic        clk_sys,
   output var  logic [6:0]  address    = 7'h7f,
   output var  logic        read       = 1'b0,
   output var  logic        write      = 1'b0,
   output var  logic [3:0]  byteenable = 4'h0,
   output var  logic [31:0] writedata  = 32'h0000_0000,
   input  wire logic [31:0] readdata,
   input  wire logic        waitrequest
);
   task automatic acc(input logic w, input logic [6:0] a, input logic [3:0] be, input logic [31:0] d,
                      output logic [31:0] q, output logic ok);
      int n;
      n = 0;
      ok = 1'b0;
      @(posedge clk_sys);
      address <= a;
      byteenable <= be;
      writedata <= d;
      read <= !w;
      write <= w;
      // waitrequest and readdata are sampled on the rising edge at which the request is taken
      while (n < 20 && !ok) begin
         @(posedge clk_sys);
         ok = !waitrequest;
         q = readdata;
         n++;
      end
      read <= 1'b0;
      write <= 1'b0;
      // released address and data lines must not keep the last value; byteenable keeps it
      writedata <= ~d;
      address <= ~a;
   endtask
endmodule
`default_nettype wire

// >>> verification/mbxhs_mailbox_handshake_bench.sv
/*
 self-checking bench: two processor models exchange data through the mailboxes.
 assumes the checker is bound to the design and a 250 MHz clk_sys.
*/
`timescale 1ns/1ps
`default_nettype none
module mbxhs_mailbox_handshake_bench;
   logic clk_sys = 1'b0;
   logic reset = 1'b1;
   logic master_reset = 1'b0;
   logic slave_reset = 1'b0;
   logic [6:0] m_address, s_address;
   logic m_read, m_write, s_read, s_write, m_waitrequest, s_waitrequest, slave_reset_out, ok;
   logic [3:0] m_byteenable, s_byteenable;
   logic [31:0] m_writedata, s_writedata, m_readdata, s_readdata, q, d1;
   logic [31:0] rnd = 32'h0000_a3b5;
   logic [7:0] m_irq, s_irq;
   int fails = 0;
   int compares = 0;
   int mi[8], si[8];
   mbxhs_mailbox_handshake i_dut (.*);
   mbxhs_cpu i_mcpu (.clk_sys(clk_sys), .address(m_address), .read(m_read), .write(m_write), .byteenable(m_byteenable),
      .writedata(m_writedata), .readdata(m_readdata), .waitrequest(m_waitrequest));
   mbxhs_cpu i_scpu (.clk_sys(clk_sys), .address(s_address), .read(s_read), .write(s_write), .byteenable(s_byteenable),
      .writedata(s_writedata), .readdata(s_readdata), .waitrequest(s_waitrequest));
   initial forever #2 clk_sys = ~clk_sys;
   // counts interrupt pulses per block on each side
   always @(posedge clk_sys) begin
      for (int i = 0; i < 8; i++) begin
         mi[i] <= mi[i] + m_irq[i];
         si[i] <= si[i] + s_irq[i];
      end
   end
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   task automatic stop_test;
      $display("compares %0d fails %0d", compares, fails);
      if (fails == 0 && compares > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   task automatic chk(input logic [31:0] act, input logic [31:0] exp);
      compares++;
      if (act !== exp) begin
         fails++;
         $display("[ERR] %0t got %h want %h", $time, act, exp);
      end
   endtask
   task automatic bus(input logic s, input logic w, input logic [6:0] a, input logic [3:0] be, input logic [31:0] d);
      if (s)
         i_scpu.acc(w, a, be, d, q, ok);
      else
         i_mcpu.acc(w, a, be, d, q, ok);
      if (ok !== 1'b1) begin
         fails++;
         $display("[ERR] %0t bus timeout", $time);
         stop_test();
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge clk_sys);
   endtask
   // ***************************************************************
   // main sequence
   // ***************************************************************
   initial begin
      repeat (3) @(posedge clk_sys);
      reset <= 1'b0;
      bus(0, 1, 7'h50, 4'hf, rnd);
      bus(0, 0, 7'h50, 4'hf, 0);
      chk(q, 0);
      bus(0, 1, 7'h44, 4'hf, 32'h0000_0f95);
      bus(0, 1, 7'h48, 4'hf, 32'h0000_0003);
      bus(0, 1, 7'h4c, 4'hf, 32'h0000_8020);
      d1 = lfsr(rnd);
      rnd = lfsr(d1);
      bus(0, 1, 7'h14, 4'h1, d1);
      cyc(6);
      bus(1, 0, 7'h40, 4'hf, 0);
      chk(q[7:0], 0);
      bus(0, 1, 7'h14, 4'h2, rnd);
      bus(0, 0, 7'h40, 4'hf, 0);
      chk(q[0], 1);
      cyc(6);
      chk(si[0], 1);
      bus(1, 0, 7'h40, 4'hf, 0);
      chk(q[0], 1);
      bus(1, 0, 7'h14, 4'h1, 0);
      cyc(6);
      chk(mi[0], 0);
      bus(1, 0, 7'h14, 4'h3, 0);
      chk(q, {16'h0000, rnd[15:8], d1[7:0]});
      cyc(6);
      chk(mi[0], 1);
      bus(0, 0, 7'h40, 4'hf, 0);
      chk(q[0], 0);
      bus(1, 0, 7'h14, 4'h3, 0);
      chk(q, {16'h0000, rnd[15:8], d1[7:0]});
      cyc(6);
      chk(mi[0], 1);
      $display("test transfer done");
      rnd = lfsr(rnd);
      bus(1, 1, 7'h20, 4'h3, d1);
      bus(1, 1, 7'h24, 4'h3, rnd);
      slave_reset <= 1'b1;
      cyc(1);
      slave_reset <= 1'b0;
      cyc(6);
      chk(mi[1], 1);
      bus(0, 0, 7'h40, 4'hf, 0);
      chk(q[1], 1);
      bus(1, 0, 7'h40, 4'hf, 0);
      chk(q[1], 1);
      bus(0, 0, 7'h24, 4'h2, 0);
      chk(q, {16'h0000, rnd[15:0]});
      bus(0, 0, 7'h20, 4'h3, 0);
      chk(q, {16'h0000, d1[15:0]});
      cyc(6);
      chk(si[1], 1);
      $display("test slave reset done");
      rnd = lfsr(rnd);
      bus(0, 1, 7'h14, 4'h3, rnd);
      master_reset <= 1'b1;
      cyc(1);
      master_reset <= 1'b0;
      cyc(6);
      chk(si[0], 1);
      bus(1, 0, 7'h40, 4'hf, 0);
      chk(q[7:0], 0);
      bus(0, 0, 7'h40, 4'hf, 0);
      chk(q[7:0], 0);
      bus(1, 0, 7'h14, 4'h1, 0);
      chk(q, {16'h0000, rnd[15:0]});
      $display("test master reset done");
      bus(0, 1, 7'h3c, 4'h3, rnd);
      cyc(6);
      chk(si[2], 0);
      bus(1, 0, 7'h40, 4'hf, 0);
      chk(q[2], 0);
      bus(0, 1, 7'h48, 4'hf, 32'h0000_0007);
      bus(0, 1, 7'h3c, 4'h3, rnd);
      cyc(6);
      chk(si[2], 1);
      $display("test enables done");
      stop_test();
   end
endmodule
`default_nettype wire
